// [logic/zwpt_top.sv]
// zone condition and write pointer tracker with APB register access
//
// Notes on behaviour
// - each zone is conventional or sequential-required
// - conventional zones: no pointer, no sequence errors
// - one in-zone write pointer per sequential zone
// - successful write moves pointer past last block
// - write reaching zone end makes zone full
// - pointer reset loads zone first block
// - reset, format and sanitize all reset pointers
// - pointer reset leaves zone empty
// - six zone conditions, no read-only or offline
// - zone state survives hard and unit reset
// - power-on condition derived from restored pointer
// - empty zone pointer equals first block
// - empty report: valid pointer, flags cleared
// - read of empty zone ends in error
// - close or reset on empty: no change
// - write command opens empty zone implicitly
// - writes accepted only at the write pointer
// - open command opens empty zone explicitly
// - close goes closed, or empty at first block
// - full: pointer invalid, close/finish no error
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/10ps
module zwpt_top
   import zwpt_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output      logic [31:0] PRDATA,
   output      logic        PREADY,
   output      logic        PSLVERR
);

   // ***********************************************
   // state and zone table
   // ***********************************************
   zwpt_state_s st;
   zwpt_state_s next_st;
   zwpt_entry_s cur;
   zwpt_entry_s mem_wd;
   logic        mem_we;
   logic [ZWPT_ENTRY_W-1:0] mem_rd;

   assign cur = zwpt_entry_s'(mem_rd);

   zwpt_mem #(  // one entry per zone, one pointer per sequential zone
      .WIDTH (ZWPT_ENTRY_W),
      .DEPTH (ZWPT_ZONES),
      .AW    (ZWPT_ZONE_W)
   ) u_table (
      .clk     (SYS_CLK),
      .rd_addr (st.zone),
      .rd_data (mem_rd),
      .wr_en   (mem_we),
      .wr_addr (st.zone),
      .wr_data (mem_wd)
   );

   // zone boundaries; zone size is a power of two
   logic [31:0] first32;
   logic [31:0] last32;
   logic [31:0] end32;
   logic [ZWPT_WP_W-1:0] first_wp;

   assign first32  = 32'(st.zone) << ZWPT_ZONE_SHIFT;
   assign last32   = first32 + ZWPT_ZONE_BLOCKS - 32'h1;
   assign end32    = 32'(st.lba) + 32'(st.count) - 32'h1;
   assign first_wp = ZWPT_WP_W'(first32);

   // ***********************************************
   // apply one operation to the fetched entry
   // ***********************************************
   logic       ok;
   logic [1:0] code;
   zwpt_entry_s upd;
   logic       upd_we;

   always_comb begin
      ok     = 1'b1;
      code   = ERR_NONE;
      upd    = cur;
      upd_we = 1'b0;
      case (st.opcode)
         OP_WRITE: begin
            if (cur.conv) begin
               // conventional zone: plain write, pointer untouched
               ok = 1'b1;
            end else if (st.count == '0 || end32 > last32) begin
               ok   = 1'b0;
               code = ERR_RANGE;
            end else if (cur.cond == state_all_blocks_written || 32'(st.lba) != 32'(cur.wp)) begin
               // must start exactly at the pointer
               ok   = 1'b0;
               code = ERR_ALIGN;
            end else begin
               upd_we  = 1'b1;
               upd.wp  = ZWPT_WP_W'(end32 + 32'h1);
               if (end32 == last32) begin
                  upd.cond = state_all_blocks_written;
               end else if (cur.cond == state_no_blocks_written ||
                            cur.cond == state_partially_written_idle) begin
                  upd.cond = state_opened_by_write;
               end
            end
         end
         OP_READ: begin
            if (st.count == '0 || end32 > last32) begin
               ok   = 1'b0;
               code = ERR_RANGE;
            end else if (!cur.conv && cur.cond == state_no_blocks_written) begin
               // empty zone holds no data: terminate rather than pattern
               ok   = 1'b0;
               code = ERR_STATE;
            end else if (!cur.conv && cur.cond != state_all_blocks_written && 32'(cur.wp) <= end32) begin
               ok   = 1'b0;
               code = ERR_RANGE;
            end
         end
         OP_OPEN: begin
            if (cur.conv || cur.cond == state_all_blocks_written) begin
               ok   = 1'b0;
               code = ERR_STATE;
            end else begin
               upd_we   = 1'b1;
               upd.cond = state_opened_by_request;
            end
         end
         OP_CLOSE: begin
            if (cur.conv) begin
               ok   = 1'b0;
               code = ERR_STATE;
            end else if (cur.cond == state_opened_by_write || cur.cond == state_opened_by_request) begin
               upd_we   = 1'b1;
               upd.cond = (cur.wp == first_wp) ? state_no_blocks_written
                                               : state_partially_written_idle;
            end
            // empty, closed and full stay put without error
         end
         OP_FINISH: begin
            if (cur.conv) begin
               ok   = 1'b0;
               code = ERR_STATE;
            end else if (cur.cond != state_all_blocks_written) begin
               upd_we   = 1'b1;
               upd.cond = state_all_blocks_written;
               upd.wp   = ZWPT_WP_W'(last32 + 32'h1);
            end
         end
         OP_RESET_WP, OP_FORMAT, OP_SANITIZE: begin
            // format and sanitize sweep every zone through this path
            if (!cur.conv) begin
               upd_we   = 1'b1;
               upd.wp   = first_wp;
               upd.cond = state_no_blocks_written;
            end
         end
         OP_RESTORE: begin
            // power-on load: condition follows the pointer
            if (cur.conv || 32'(st.lba) < first32 || 32'(st.lba) > last32 + 32'h1) begin
               ok   = 1'b0;
               code = ERR_RANGE;
            end else begin
               upd_we = 1'b1;
               upd.wp = st.lba;
               if (st.lba == first_wp) begin
                  upd.cond = state_no_blocks_written;
               end else if (32'(st.lba) <= last32) begin
                  upd.cond = state_partially_written_idle;
               end else begin
                  upd.cond = state_all_blocks_written;
               end
            end
         end
         OP_SET_TYPE: begin
            upd_we    = 1'b1;
            upd.conv  = st.lba[0];
            upd.wp    = first_wp;
            upd.cond  = st.lba[0] ? cond_no_write_pointer : state_no_blocks_written;
         end
         OP_REPORT: begin
            ok = 1'b1;
         end
         default: begin
            ok   = 1'b0;
            code = ERR_STATE;
         end
      endcase
   end

   assign mem_we = (st.fsm == ST_APPLY) && upd_we;
   assign mem_wd = upd;

   // ***********************************************
   // bus decode and sequencing
   // ***********************************************
   logic bus_access;
   logic bus_commit;
   logic known_addr;

   assign bus_access = PSEL && PENABLE && !st.pready;
   assign bus_commit = PSEL && PENABLE && st.pready;
   assign known_addr = PADDR == ADDR_LBA || PADDR == ADDR_COUNT || PADDR == ADDR_CMD ||
                       PADDR == ADDR_STATUS || PADDR == ADDR_REP_COND || PADDR == ADDR_REP_WP;

   always_comb begin
      next_st         = st;
      next_st.pready  = bus_access;
      next_st.pslverr = bus_access && !known_addr;
      next_st.prdata  = '0;
      if (bus_access && !PWRITE) begin
         case (PADDR)
            ADDR_LBA:      next_st.prdata = 32'(st.lba);
            ADDR_COUNT:    next_st.prdata = 32'(st.count);
            ADDR_CMD:      next_st.prdata = {16'h0000, 4'h0, st.zone, 4'h0, st.opcode};
            ADDR_STATUS:   next_st.prdata = {26'h0, st.overrun, st.err_code, st.err, st.done, st.busy};
            // reset-recommended and non-sequential flags always read zero
            ADDR_REP_COND: next_st.prdata = {25'h0, 1'b0, 1'b0, st.rep_wp_valid, st.rep_conv, st.rep_cond};
            ADDR_REP_WP:   next_st.prdata = 32'(st.rep_wp);
            default:       next_st.prdata = '0;
         endcase
      end
      if (bus_commit && PWRITE) begin
         case (PADDR)
            ADDR_LBA:    next_st.lba = ZWPT_WP_W'(PWDATA);
            ADDR_COUNT:  next_st.count = ZWPT_CNT_W'(PWDATA);
            ADDR_STATUS: begin
               if (PWDATA[STAT_OVR_BIT]) begin
                  next_st.overrun = 1'b0;
               end
            end
            default: ;
         endcase
      end

      case (st.fsm)
         ST_IDLE: begin
            if (bus_commit && PWRITE && PADDR == ADDR_CMD) begin
               next_st.opcode = PWDATA[CMD_OP_LSB +: 4];
               next_st.zone   = PWDATA[CMD_ZONE_LSB +: ZWPT_ZONE_W];
               next_st.sweep  = 1'b0;
               if (PWDATA[CMD_OP_LSB +: 4] == OP_FORMAT || PWDATA[CMD_OP_LSB +: 4] == OP_SANITIZE) begin
                  next_st.zone  = '0;
                  next_st.sweep = 1'b1;
               end
               next_st.busy     = 1'b1;
               next_st.done     = 1'b0;
               next_st.err      = 1'b0;
               next_st.err_code = ERR_NONE;
               next_st.fsm      = ST_FETCH;
            end
         end
         ST_FETCH: begin
            next_st.fsm = ST_APPLY;
         end
         ST_APPLY: begin
            // read-modify-write completes here before any new command
            if (!ok) begin
               next_st.err      = 1'b1;
               next_st.err_code = code;
            end
            if (st.opcode == OP_REPORT) begin
               next_st.rep_conv     = cur.conv;
               next_st.rep_cond     = cur.conv ? cond_no_write_pointer : cur.cond;
               next_st.rep_wp_valid = !cur.conv && cur.cond != state_all_blocks_written;
               next_st.rep_wp       = cur.wp;
            end
            if (st.sweep && st.zone != ZWPT_ZONE_W'(ZWPT_ZONES - 1)) begin
               next_st.zone = st.zone + 1'b1;
               next_st.fsm  = ST_FETCH;
            end else begin
               next_st.busy = 1'b0;
               next_st.done = 1'b1;
               next_st.fsm  = ST_IDLE;
            end
         end
         default: begin
            next_st.fsm = ST_IDLE;
         end
      endcase

      // a command while busy is dropped and flagged; set beats clear
      if (st.busy && bus_commit && PWRITE && PADDR == ADDR_CMD) begin
         next_st.overrun = 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         // zone table is not touched: conditions hold through reset
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign PRDATA  = st.prdata;
   assign PREADY  = st.pready;
   assign PSLVERR = st.pslverr;

   // ***********************************************
   // checks
   // ***********************************************
   logic apply_swr_write;

   assign apply_swr_write = st.fsm == ST_APPLY && st.opcode == OP_WRITE && !cur.conv;

   a_write_align: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      apply_swr_write && st.count != '0 && end32 <= last32 && 32'(st.lba) != 32'(cur.wp)
      |-> !mem_we ##1 (st.err && st.err_code == ERR_ALIGN))
      else $error("misaligned write was not refused");

   a_wp_advance: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      apply_swr_write && ok |-> mem_we && 32'(mem_wd.wp) == 32'(st.lba) + 32'(st.count))
      else $error("write pointer did not advance by the block count");

   a_fill_full: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      apply_swr_write && ok && end32 == last32 |-> mem_wd.cond == state_all_blocks_written)
      else $error("zone filled to the end is not full");

   a_reset_empty: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_APPLY && st.opcode == OP_RESET_WP && !cur.conv
      |-> mem_we && mem_wd.wp == first_wp && mem_wd.cond == state_no_blocks_written)
      else $error("pointer reset did not leave zone empty at first block");

   a_empty_first: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      mem_we && !mem_wd.conv && mem_wd.cond == state_no_blocks_written |-> mem_wd.wp == first_wp)
      else $error("empty zone stored with pointer off its first block");

   a_conv_noerr: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_APPLY && st.opcode == OP_WRITE && cur.conv |-> !mem_we ##1 !st.err)
      else $error("conventional zone write raised an error or touched the table");

   a_empty_close: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_APPLY && !cur.conv && st.opcode == OP_CLOSE && cur.cond == state_no_blocks_written
      |-> !mem_we ##1 (!st.err && st.done))
      else $error("close of empty zone changed it or failed");

   a_open_explicit: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_APPLY && !cur.conv && st.opcode == OP_OPEN && cur.cond == state_no_blocks_written
      |-> mem_we && mem_wd.cond == state_opened_by_request)
      else $error("open of empty zone did not open it explicitly");

   a_full_steady: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_APPLY && !cur.conv && cur.cond == state_all_blocks_written &&
      (st.opcode == OP_CLOSE || st.opcode == OP_FINISH) |-> !mem_we ##1 !st.err)
      else $error("close or finish disturbed a full zone");

   a_busy_overrun: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.busy && bus_commit && PWRITE && PADDR == ADDR_CMD |=> st.overrun && $stable(st.opcode))
      else $error("command accepted while another was in progress");

   a_cmd_finish: assert property (
      @(posedge SYS_CLK) disable iff (!NRST)
      st.fsm == ST_IDLE && bus_commit && PWRITE && PADDR == ADDR_CMD &&
      PWDATA[CMD_OP_LSB +: 4] == OP_OPEN |=> st.busy ##2 (st.done && !st.busy))
      else $error("single-zone command did not finish in three cycles");

endmodule

// [logic/zwpt_pkg.sv]
// shared constants, encodings and carrier types for the zone write pointer tracker
package zwpt_pkg;

   // ***********************************************
   // geometry
   // ***********************************************
   localparam int ZWPT_ZONE_W     = 4;
   localparam int ZWPT_ZONE_SHIFT = 8;
   localparam int ZWPT_LBA_W      = ZWPT_ZONE_W + ZWPT_ZONE_SHIFT;
   // one spare bit so a full zone can hold last block plus one
   localparam int ZWPT_WP_W       = ZWPT_LBA_W + 1;
   localparam int ZWPT_CNT_W      = 16;
   localparam int ZWPT_ZONES      = 1 << ZWPT_ZONE_W;
   localparam logic [31:0] ZWPT_ZONE_BLOCKS = 32'h1 << ZWPT_ZONE_SHIFT;

   // ***********************************************
   // register offsets (byte addresses)
   // ***********************************************
   localparam logic [7:0] ADDR_LBA      = 8'h00;
   localparam logic [7:0] ADDR_COUNT    = 8'h04;
   localparam logic [7:0] ADDR_CMD      = 8'h08;
   localparam logic [7:0] ADDR_STATUS   = 8'h0C;
   localparam logic [7:0] ADDR_REP_COND = 8'h10;
   localparam logic [7:0] ADDR_REP_WP   = 8'h14;

   // command field layout in the command register, and the overrun bit in the status register
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_ZONE_LSB = 8;
   localparam int STAT_OVR_BIT = 5;

   // ***********************************************
   // operation codes
   // ***********************************************
   localparam logic [3:0] OP_WRITE    = 4'h1;
   localparam logic [3:0] OP_READ     = 4'h2;
   localparam logic [3:0] OP_OPEN     = 4'h3;
   localparam logic [3:0] OP_CLOSE    = 4'h4;
   localparam logic [3:0] OP_FINISH   = 4'h5;
   localparam logic [3:0] OP_RESET_WP = 4'h6;
   localparam logic [3:0] OP_FORMAT   = 4'h7;
   localparam logic [3:0] OP_SANITIZE = 4'h8;
   localparam logic [3:0] OP_RESTORE  = 4'h9;
   localparam logic [3:0] OP_SET_TYPE = 4'hA;
   localparam logic [3:0] OP_REPORT   = 4'hB;

   // ***********************************************
   // zone condition codes (three-bit field)
   // ***********************************************
   localparam logic [2:0] cond_no_write_pointer          = 3'h0;
   localparam logic [2:0] state_no_blocks_written        = 3'h1;
   localparam logic [2:0] state_opened_by_write          = 3'h2;
   localparam logic [2:0] state_opened_by_request        = 3'h3;
   localparam logic [2:0] state_partially_written_idle   = 3'h4;
   localparam logic [2:0] state_all_blocks_written       = 3'h5;

   // error codes
   localparam logic [1:0] ERR_NONE    = 2'h0;
   localparam logic [1:0] ERR_ALIGN   = 2'h1;
   localparam logic [1:0] ERR_RANGE   = 2'h2;
   localparam logic [1:0] ERR_STATE   = 2'h3;

   // ***********************************************
   // types
   // ***********************************************
   typedef struct packed {
      logic                 conv;
      logic [2:0]           cond;
      logic [ZWPT_WP_W-1:0] wp;
   } zwpt_entry_s;

   localparam int ZWPT_ENTRY_W = $bits(zwpt_entry_s);

   typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_APPLY} zwpt_fsm_e;

   typedef struct packed {
      zwpt_fsm_e             fsm;
      logic [3:0]            opcode;
      logic [ZWPT_ZONE_W-1:0] zone;
      logic                  sweep;
      logic [ZWPT_WP_W-1:0]  lba;
      logic [ZWPT_CNT_W-1:0] count;
      logic                  busy;
      logic                  done;
      logic                  err;
      logic [1:0]            err_code;
      logic                  overrun;
      logic                  rep_conv;
      logic [2:0]            rep_cond;
      logic                  rep_wp_valid;
      logic [ZWPT_WP_W-1:0]  rep_wp;
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
   } zwpt_state_s;

endpackage

// [logic/zwpt_mem.sv]
// zone table memory with registered read data
`timescale 1ns/10ps
module zwpt_mem #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   input  wire logic             clk,
   input  wire logic [AW-1:0]    rd_addr,
   output      logic [WIDTH-1:0] rd_data,
   input  wire logic             wr_en,
   input  wire logic [AW-1:0]    wr_addr,
   input  wire logic [WIDTH-1:0] wr_data
);

   // no reset: zone state must survive hard and unit resets
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule

// [testbench/zwpt_host.sv]
// host-side apb master model issuing zone commands
`timescale 1ns/10ps
module zwpt_host
   import zwpt_pkg::*;
(
   input  wire logic        clk,
   output      logic        psel,
   output      logic        penable,
   output      logic        pwrite,
   output      logic [7:0]  paddr,
   output      logic [31:0] pwdata,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   logic [31:0] rdata;
   logic        rerr;

   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 8'h00;
      pwdata  = 32'h0;
      rdata   = 32'h0;
      rerr    = 1'b0;
   end

   // ***********************************************
   // bus transfers
   // ***********************************************
   // one idle cycle at the end so psel is never assigned twice in a step
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata   = prdata;
      rerr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // released lines must not keep looking valid
      paddr   <= ~a;
      pwdata  <= ~d;
      @(posedge clk);
   endtask

   // waits for done before returning, never stacks commands
   task automatic cmd(input logic [3:0] op, input logic [3:0] z, input logic [12:0] lba, input logic [15:0] cnt);
      xfer(1'b1, ADDR_LBA, {19'h0, lba});
      xfer(1'b1, ADDR_COUNT, {16'h0, cnt});
      xfer(1'b1, ADDR_CMD, {20'h0, z, 4'h0, op});
      rdata = 32'h0;
      while (rdata[1:0] !== 2'b10) begin
         xfer(1'b0, ADDR_STATUS, 32'h0);
      end
   endtask
endmodule

// [testbench/zwpt_top_tb.sv]
// self-checking bench for the zone write pointer tracker
`timescale 1ns/10ps
module zwpt_top_tb
   import zwpt_pkg::*;
;
   typedef struct packed {logic [31:0] op, zone, lba, cnt, err, rep, wp;} zwpt_row_s;

   logic        sys_clk;
   logic        nrst;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   int          bad_count = 0;
   int          checked = 0;
   int          cycles = 0;
   zwpt_row_s   r;

   // op, zone, lba, count, {code,err}, {wp_valid,conv,cond}, wp
   zwpt_row_s rows [0:26] = '{
      '{OP_REPORT, 1, 0, 1, 0, 'h11, 'h100},
      '{OP_RESTORE, 3, 'h310, 1, 0, 'h14, 'h310},
      '{OP_REPORT, 2, 0, 1, 0, 'h08, 0},
      '{OP_READ, 1, 'h100, 1, 7, 'h11, 'h100},
      '{OP_CLOSE, 1, 0, 1, 0, 'h11, 'h100},
      '{OP_RESET_WP, 1, 0, 1, 0, 'h11, 'h100},
      '{OP_WRITE, 1, 'h101, 1, 3, 'h11, 'h100},
      '{OP_WRITE, 1, 'h100, 'h10, 0, 'h12, 'h110},
      '{OP_CLOSE, 1, 0, 1, 0, 'h14, 'h110},
      '{OP_OPEN, 1, 0, 1, 0, 'h13, 'h110},
      '{OP_WRITE, 1, 'h110, 'hF0, 0, 'h05, 0},
      '{OP_CLOSE, 1, 0, 1, 0, 'h05, 0},
      '{OP_FINISH, 1, 0, 1, 0, 'h05, 0},
      '{OP_RESET_WP, 1, 0, 1, 0, 'h11, 'h100},
      '{OP_OPEN, 1, 0, 1, 0, 'h13, 'h100},
      '{OP_CLOSE, 1, 0, 1, 0, 'h11, 'h100},
      '{OP_WRITE, 2, 'h234, 4, 0, 'h08, 0},
      '{4'hC, 1, 0, 1, 7, 'h11, 'h100},
      '{OP_READ, 3, 'h300, 'h10, 0, 'h14, 'h310},
      '{OP_READ, 3, 'h308, 'h10, 5, 'h14, 'h310},
      '{OP_FINISH, 3, 0, 1, 0, 'h05, 0},
      '{OP_OPEN, 2, 0, 1, 7, 'h08, 0},
      '{OP_RESTORE, 4, 'h500, 1, 0, 'h05, 0},
      '{OP_FORMAT, 3, 0, 1, 0, 'h11, 'h300},
      '{OP_WRITE, 3, 'h300, 1, 0, 'h12, 'h301},
      '{OP_SANITIZE, 3, 0, 1, 0, 'h11, 'h300},
      '{OP_WRITE, 3, 'h300, 8, 0, 'h12, 'h308}
   };

   zwpt_top u_dut (
      .SYS_CLK (sys_clk),
      .NRST    (nrst),
      .PSEL    (psel),
      .PENABLE (penable),
      .PWRITE  (pwrite),
      .PADDR   (paddr),
      .PWDATA  (pwdata),
      .PRDATA  (prdata),
      .PREADY  (pready),
      .PSLVERR (pslverr)
   );

   zwpt_host u_host (
      .clk     (sys_clk),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .prdata  (prdata),
      .pready  (pready),
      .pslverr (pslverr)
   );

   // ***********************************************
   // checking and reporting
   // ***********************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic report_zone(input logic [3:0] z, input logic [31:0] rep, input logic [31:0] wp);
      u_host.cmd(OP_REPORT, z, 13'h0, 16'h1);
      u_host.xfer(1'b0, ADDR_REP_COND, 32'h0);
      check({25'h0, u_host.rdata[6:0]}, rep);
      if (rep[4]) begin
         u_host.xfer(1'b0, ADDR_REP_WP, 32'h0);
         check(u_host.rdata, wp);
      end
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ceiling well above the roughly 1750 cycles the tests need
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         bad_count++;
         results();
      end
   end

   initial begin
      nrst = 1'b0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      // zone table powers up unknown: type every zone (zone 2 as conventional), then restore every other zone at its first block
      for (int z = 0; z < 16; z++) begin
         u_host.cmd(OP_SET_TYPE, z[3:0], {12'h0, z == 2}, 16'h1);
         if (z != 2) begin
            u_host.cmd(OP_RESTORE, z[3:0], 13'(z << 8), 16'h1);
         end
      end
      foreach (rows[i]) begin
         r = rows[i];
         u_host.cmd(r.op[3:0], r.zone[3:0], r.lba[12:0], r.cnt[15:0]);
         check({29'h0, u_host.rdata[4:2]}, r.err);
         report_zone(r.zone[3:0], r.rep, r.wp);
      end
      $display("zone command table done");
      nrst <= 1'b0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      u_host.xfer(1'b0, ADDR_STATUS, 32'h0);
      check(u_host.rdata, 32'h0);
      report_zone(4'h3, 'h12, 'h308);
      $display("reset hold test done");
      u_host.xfer(1'b0, 8'h18, 32'h0);
      check({31'h0, u_host.rerr}, 32'h1);
      check(u_host.rdata, 32'h0);
      $display("unmapped access test done");
      u_host.xfer(1'b1, ADDR_CMD, {28'h0, OP_FORMAT});
      u_host.xfer(1'b1, ADDR_CMD, {20'h0, 4'h1, 4'h0, OP_REPORT});
      u_host.xfer(1'b0, ADDR_STATUS, 32'h0);
      check(u_host.rdata & 32'h21, 32'h21);
      while (u_host.rdata[1:0] !== 2'b10) begin
         u_host.xfer(1'b0, ADDR_STATUS, 32'h0);
      end
      u_host.xfer(1'b1, ADDR_STATUS, 32'h20);
      u_host.xfer(1'b0, ADDR_STATUS, 32'h0);
      check({31'h0, u_host.rdata[5]}, 32'h0);
      report_zone(4'h3, 'h11, 'h300);
      $display("overrun test done");
      results();
   end
endmodule
